/* File: verilog/fogsw_pkg.sv */
// Purpose: shared constants and types for the fanout output gate and serial write target
// Assumes: nine differential outputs, output clock is the reference clock divided by two
// Notes:   configuration bytes hold enables, slew, amplitude and a byte count
`default_nettype none

package fogsw_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int         NUM_OUT        = 9;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    // output gating latency in output clock periods, one output period is two clk cycles
    localparam int         OE_LAT_MIN_PER = 1;
    localparam int         OE_LAT_MAX_PER = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // target address choices of the three-level select pin
    localparam logic [1:0] SEL_LOW   = 2'h0;
    localparam logic [1:0] SEL_MID   = 2'h1;
    localparam logic [1:0] SEL_HIGH  = 2'h2;
    localparam logic [6:0] ADDR_LOW  = 7'h6b;
    localparam logic [6:0] ADDR_MID  = 7'h6c;
    localparam logic [6:0] ADDR_HIGH = 7'h6d;

    ////////////////////////////////////////////////////////////////////////////////
    // register indexes and field positions
    localparam logic [7:0] IDX_OE_LO    = 8'h00;
    localparam logic [7:0] IDX_OE_AMP   = 8'h01;
    localparam logic [7:0] IDX_SLEW_LO  = 8'h02;
    localparam logic [7:0] IDX_SLEW_HI  = 8'h03;
    localparam logic [7:0] IDX_REV_VEND = 8'h05;
    localparam logic [7:0] IDX_BCOUNT   = 8'h07;
    localparam int         BIT_OE8      = 5;
    localparam int         BIT_SLEW8    = 0;
    localparam int         BC_W         = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [8:0]      DEF_EN    = 9'h1ff;
    localparam logic [8:0]      DEF_SLEW  = 9'h1ff;
    localparam logic [1:0]      DEF_AMP   = 2'h2;
    localparam logic [BC_W-1:0] DEF_BC    = 5'h08;
    // pins idle: bus lines high, power good low, everything else low
    localparam logic [13:0]     PINS_RST  = 14'h3000;

    ////////////////////////////////////////////////////////////////////////////////
    // byte roles within one block write
    localparam logic [1:0] ROLE_ADDR  = 2'h0;
    localparam logic [1:0] ROLE_INDEX = 2'h1;
    localparam logic [1:0] ROLE_COUNT = 2'h2;
    localparam logic [1:0] ROLE_DATA  = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_ACK} fogsw_state_e;

    typedef struct packed {
        logic [8:0]      en;
        logic [8:0]      slew;
        logic [1:0]      amp;
        logic [BC_W-1:0] bcount;
    } fogsw_cfg_s;

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       pg;
        logic [1:0] addr_sel;
        logic [8:0] oe;
    } fogsw_pins_s;

endpackage : fogsw_pkg

`default_nettype wire

/* File: verilog/fogsw_pin_sync.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes:   a change is taken once stages two and three agree
`default_nettype none

module fogsw_pin_sync
    import fogsw_pkg::*;
#(
    parameter int          W   = 14,
    parameter logic [13:0] RST = PINS_RST
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] pin_in,
    output var  logic [W-1:0] pin_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    ////////////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second, filter looks at stages two and three
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_r    <= RST[W-1:0];
            s2_r    <= RST[W-1:0];
            s3_r    <= RST[W-1:0];
            pin_out <= RST[W-1:0];
        end else begin
            s1_r    <= pin_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            pin_out <= (s2_r & ~(s2_r ^ s3_r)) | (pin_out & (s2_r ^ s3_r));
        end
    end

endmodule : fogsw_pin_sync

`default_nettype wire

/* File: verilog/fogsw_top.sv */
// Purpose: output gating of a differential fanout buffer plus a serial block-write target
// Assumes: clk is the running reference clock; outputs toggle at clk/2
// Notes:   block reads are not served; target answers only while clk runs
`default_nettype none

// Functional notes
// - power good low forces all outputs low
// - enable pin zero forces output low
// - all conditions true lets clock through
// - matching write address byte is acknowledged
// - index byte acknowledged, sets first register
// - count byte acknowledged and stored
// - data bytes up to the count stored at consecutive indexes, acknowledged
// - pin change acts within 1-3 periods
// - address strap sampled at first power good
// - serial target runs only on reference clock
module fogsw_top (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       power_good_powerdown_n,
    input  wire logic [1:0] address_select_three_level,
    input  wire logic [8:0] output_enable_pin,
    input  wire logic       smbus_clock,
    input  wire logic       smbus_data_in,
    output var  logic       smbus_data_out,
    output var  logic       smbus_data_oe_n,
    output var  logic [8:0] differential_clock_output_true,
    output var  logic [8:0] differential_clock_output_comp,
    output var  logic [8:0] slew_fast,
    output var  logic [1:0] amplitude
);
    import fogsw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [6:0] addr_of(input logic [1:0] sel);
        addr_of = (sel == SEL_LOW) ? ADDR_LOW : (sel == SEL_MID) ? ADDR_MID : ADDR_HIGH;
    endfunction : addr_of

    // only writable fields move; reserved and read-only indexes fall through
    function automatic fogsw_cfg_s cfg_write(input fogsw_cfg_s c, input logic [7:0] idx,
                                             input logic [7:0] d);
        cfg_write = c;
        case (idx)
            IDX_OE_LO:   cfg_write.en[7:0]    = d;
            IDX_OE_AMP: begin
                cfg_write.en[8] = d[BIT_OE8];
                cfg_write.amp   = d[1:0];
            end
            IDX_SLEW_LO: cfg_write.slew[7:0]  = d;
            IDX_SLEW_HI: cfg_write.slew[8]    = d[BIT_SLEW8];
            IDX_BCOUNT:  cfg_write.bcount     = d[BC_W-1:0];
            default:     cfg_write            = c;
        endcase
    endfunction : cfg_write

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    fogsw_pins_s pins_raw;
    fogsw_pins_s pins_s;

    assign pins_raw = '{scl: smbus_clock, sda: smbus_data_in, pg: power_good_powerdown_n,
                        addr_sel: address_select_three_level, oe: output_enable_pin};

    fogsw_pin_sync #(.W(14), .RST(PINS_RST)) u_sync (
        .clk     (clk),
        .reset   (reset),
        .pin_in  (pins_raw),
        .pin_out (pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // state
    fogsw_cfg_s   cfg_r;
    fogsw_cfg_s   cfg_nxt;
    fogsw_state_e st_r;
    logic [7:0]   shift_r;
    logic [3:0]   bit_cnt_r;
    logic [1:0]   role_r;
    logic [7:0]   idx_r;
    logic [7:0]   left_r;
    logic         scl_prev_r;
    logic         sda_prev_r;
    logic         pg_prev_r;
    logic         addr_taken_r;
    logic [6:0]   tgt_addr_r;
    logic         phase_r;
    logic [8:0]   gate_r;

    ////////////////////////////////////////////////////////////////////////////////
    // bus event decode, all on the reference clock
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       byte_done;
    logic       addr_ok;
    logic       do_ack;
    logic       wr_data;

    assign scl_rise  = pins_s.scl & ~scl_prev_r;
    assign scl_fall  = ~pins_s.scl & scl_prev_r;
    assign start_det = pins_s.scl & scl_prev_r & sda_prev_r & ~pins_s.sda;
    assign stop_det  = pins_s.scl & scl_prev_r & ~sda_prev_r & pins_s.sda;
    assign byte_done = scl_fall && (st_r == ST_RECV) && (bit_cnt_r == BITS_PER_BYTE);
    assign addr_ok   = (shift_r == {tgt_addr_r, 1'b0});
    assign do_ack    = (role_r == ROLE_ADDR) ? addr_ok :
                       (role_r == ROLE_DATA) ? (left_r != 8'h00) : 1'b1;
    assign wr_data   = byte_done && (role_r == ROLE_DATA) && (left_r != 8'h00);
    assign cfg_nxt   = wr_data ? cfg_write(cfg_r, idx_r, shift_r) : cfg_r;

    ////////////////////////////////////////////////////////////////////////////////
    // edge history and address strap, caught after reset release
    always_ff @(posedge clk) begin
        if (reset) begin
            scl_prev_r   <= 1'b1;
            sda_prev_r   <= 1'b1;
            pg_prev_r    <= 1'b0;
            addr_taken_r <= 1'b0;
            tgt_addr_r   <= ADDR_LOW;
        end else begin
            scl_prev_r <= pins_s.scl;
            sda_prev_r <= pins_s.sda;
            pg_prev_r  <= pins_s.pg;
            if (pins_s.pg && !pg_prev_r && !addr_taken_r) begin
                tgt_addr_r   <= addr_of(pins_s.addr_sel);
                addr_taken_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write-only target; clocked by the reference so it is silent when that stops
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r            <= ST_IDLE;
            shift_r         <= 8'h00;
            bit_cnt_r       <= 4'h0;
            role_r          <= ROLE_ADDR;
            idx_r           <= 8'h00;
            left_r          <= 8'h00;
            smbus_data_oe_n <= 1'b1;
        end else if (start_det) begin
            st_r            <= ST_RECV;
            bit_cnt_r       <= 4'h0;
            role_r          <= ROLE_ADDR;
            smbus_data_oe_n <= 1'b1;
        end else if (stop_det) begin
            st_r            <= ST_IDLE;
            smbus_data_oe_n <= 1'b1;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                end
                ST_RECV: begin
                    if (scl_rise && (bit_cnt_r != BITS_PER_BYTE)) begin
                        shift_r   <= {shift_r[6:0], pins_s.sda};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    if (byte_done) begin
                        st_r            <= do_ack ? ST_ACK : ST_IDLE;
                        smbus_data_oe_n <= ~do_ack;
                        unique case (role_r)
                            ROLE_ADDR:  role_r <= ROLE_INDEX;
                            ROLE_INDEX: begin
                                idx_r  <= shift_r;
                                role_r <= ROLE_COUNT;
                            end
                            ROLE_COUNT: begin
                                left_r <= shift_r;
                                role_r <= ROLE_DATA;
                            end
                            ROLE_DATA: begin
                                idx_r  <= idx_r + 8'h01;
                                left_r <= left_r - 8'h01;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        smbus_data_oe_n <= 1'b1;
                        bit_cnt_r       <= 4'h0;
                        st_r            <= ST_RECV;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration store; data pin only ever pulls low
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_r          <= '{en: DEF_EN, slew: DEF_SLEW, amp: DEF_AMP, bcount: DEF_BC};
            smbus_data_out <= 1'b0;
        end else begin
            cfg_r          <= cfg_nxt;
            smbus_data_out <= 1'b0;
        end
    end

    assign slew_fast = cfg_r.slew;
    assign amplitude = cfg_r.amp;

    ////////////////////////////////////////////////////////////////////////////////
    // output gating; gate moves only at the end of a high phase, so no runt pulse
    logic [8:0] want;
    logic [8:0] gate_nxt;
    logic [8:0] true_nxt;
    logic [8:0] comp_nxt;

    assign want     = {NUM_OUT{pins_s.pg}} & cfg_r.en & pins_s.oe;
    assign gate_nxt = phase_r ? want : gate_r;
    assign true_nxt = gate_nxt & {NUM_OUT{pins_s.pg & ~phase_r}};
    assign comp_nxt = gate_nxt & {NUM_OUT{pins_s.pg & phase_r}};

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_r                        <= 1'b0;
            gate_r                         <= 9'h000;
            differential_clock_output_true <= 9'h000;
            differential_clock_output_comp <= 9'h000;
        end else begin
            phase_r                        <= ~phase_r;
            gate_r                         <= gate_nxt;
            differential_clock_output_true <= true_nxt;
            differential_clock_output_comp <= comp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_pd_all_low: assert property (@(posedge clk) disable iff (reset)
        !pins_s.pg |=> (differential_clock_output_true == 9'h000)
                       && (differential_clock_output_comp == 9'h000))
        else $error("output active while power good low");

    a_bit_off_low: assert property (@(posedge clk) disable iff (reset)
        (!cfg_r.en[0])[*3] |=> !differential_clock_output_true[0]
                               && !differential_clock_output_comp[0])
        else $error("output active with enable bit clear");

    a_pin_off_low: assert property (@(posedge clk) disable iff (reset)
        (!pins_s.oe[0])[*3] |=> !differential_clock_output_true[0]
                                && !differential_clock_output_comp[0])
        else $error("output active with enable pin low");

    a_clock_runs: assert property (@(posedge clk) disable iff (reset)
        (want[0])[*3] |=> (differential_clock_output_true[0]
                           != differential_clock_output_comp[0]))
        else $error("output not toggling while fully enabled");

    a_oe_latency: assert property (@(posedge clk) disable iff (reset)
        $rose(want[0]) |-> ##[1:3] (gate_r[0] || !want[0]))
        else $error("output start later than allowed");

    a_strap_addr: assert property (@(posedge clk) disable iff (reset)
        (pins_s.pg && !pg_prev_r && !addr_taken_r)
        |=> tgt_addr_r == addr_of($past(pins_s.addr_sel)))
        else $error("address strap not captured");

    a_ack_addr: assert property (@(posedge clk) disable iff (reset)
        (byte_done && role_r == ROLE_ADDR && addr_ok && !start_det && !stop_det)
        |=> !smbus_data_oe_n && st_r == ST_ACK)
        else $error("matching address not acknowledged");

    a_index_load: assert property (@(posedge clk) disable iff (reset)
        (byte_done && role_r == ROLE_INDEX && !start_det && !stop_det)
        |=> idx_r == $past(shift_r) && !smbus_data_oe_n)
        else $error("index byte not taken");

    a_count_load: assert property (@(posedge clk) disable iff (reset)
        (byte_done && role_r == ROLE_COUNT && !start_det && !stop_det)
        |=> left_r == $past(shift_r) && !smbus_data_oe_n)
        else $error("count byte not taken");

    a_data_store: assert property (@(posedge clk) disable iff (reset)
        (wr_data && idx_r == IDX_OE_LO && !start_det && !stop_det)
        |=> cfg_r.en[7:0] == $past(shift_r) && idx_r == 8'h01)
        else $error("data byte not stored");

    a_bcount_store: assert property (@(posedge clk) disable iff (reset)
        (wr_data && idx_r == IDX_BCOUNT && !start_det && !stop_det)
        |=> cfg_r.bcount == $past(shift_r[BC_W-1:0]))
        else $error("byte count not stored");

    a_ro_ignored: assert property (@(posedge clk) disable iff (reset)
        (wr_data && idx_r == IDX_REV_VEND) |=> $stable(cfg_r))
        else $error("read-only write changed state");

    a_gate_edge: assert property (@(posedge clk) disable iff (reset)
        (gate_r != $past(gate_r)) |-> $past(phase_r))
        else $error("gate changed mid high phase");

endmodule : fogsw_top

`default_nettype wire

/* File: verification/fogsw_host_model.sv */
// Purpose: serial bus host that issues index block writes to the target
// Assumes: data line pulled up, a released line reads high
// Notes:   every change lands just after a clk rise, one change per half period
`default_nettype none

module fogsw_host_model #(
    parameter int HALF = 12
) (
    input  wire logic clk,
    input  wire logic sda_wire,
    output var  logic scl,
    output var  logic sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus: both lines released
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // half period kept wide so the target's input filter sees every level
    task automatic hw();
        repeat (HALF) @(posedge clk);
        #1;
    endtask : hw

    // data only moves while clock is low, else it would read as start or stop
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            hw();
            scl = 1'b1;
            hw();
            scl = 1'b0;
            hw();
        end
        sda_drv = 1'b1;
        hw();
        scl = 1'b1;
        hw();
        ack = ~sda_wire;
        scl = 1'b0;
        hw();
    endtask : put_byte

    ////////////////////////////////////////////////////////////////////////////////
    // whole block write; gives up at the first refusal, then always stops
    task automatic write_block(input logic [6:0] a, input logic [7:0] n, input logic [7:0] x,
                               input logic [39:0] d, input int nd, output logic [7:0] acks);
        logic        ok;
        logic [63:0] seq;
        ok   = 1'b1;
        acks = 8'h00;
        seq  = {a, 1'b0, n, x, d};
        sda_drv = 1'b1;
        hw();
        scl = 1'b1;
        hw();
        sda_drv = 1'b0;
        hw();
        scl = 1'b0;
        hw();
        for (int k = 0; k < 3 + nd; k++) begin
            if (ok) begin
                put_byte(seq[63 - 8 * k -: 8], ok);
                acks[k] = ok;
            end
        end
        sda_drv = 1'b0;
        hw();
        scl = 1'b1;
        hw();
        sda_drv = 1'b1;
        hw();
    endtask : write_block

endmodule : fogsw_host_model

`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for output gating and block writes
// Assumes: outputs sampled on falling clk, inputs driven 1ns after rising clk
// Notes:   running outputs toggle every clk, so two samples show the clock
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fogsw_pkg::*;

    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       pg = 1'b0;
    logic [1:0] asel = SEL_LOW;
    logic [8:0] oe_pin = 9'h1ff;
    logic       scl;
    logic       sda_drv;
    logic       sda_wire;
    logic       data_out;
    logic       data_oe_n;
    logic [8:0] tru;
    logic [8:0] cmp;
    logic [8:0] slew;
    logic [1:0] amp;
    int         mismatches = 0;
    int         total_checks = 0;

    always #50 clk = ~clk;
    // open drain data line with pull-up
    assign sda_wire = sda_drv & (data_oe_n | data_out);

    fogsw_top DUT (
        .clk(clk), .reset(reset), .power_good_powerdown_n(pg),
        .address_select_three_level(asel), .output_enable_pin(oe_pin),
        .smbus_clock(scl), .smbus_data_in(sda_wire), .smbus_data_out(data_out),
        .smbus_data_oe_n(data_oe_n), .differential_clock_output_true(tru),
        .differential_clock_output_comp(cmp), .slew_fast(slew), .amplitude(amp)
    );

    fogsw_host_model host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD t=%0t %s", $time, m);
        end
    endtask : chk

    // running legs toggle each clk with comp inverse; stopped legs both low
    task automatic expect_out(input logic [8:0] run, input string m);
        logic [8:0] t0;
        repeat (2) begin
            @(negedge clk);
            t0 = tru;
            @(negedge clk);
            chk(((tru ^ t0) === run) && (cmp === (~tru & run)) && ((tru & ~run) === 9'h000), m);
        end
        // hand back just after a rising edge so the next pin change keeps the usual offset
        tick(1);
    endtask : expect_out

    task automatic wr(input logic [6:0] a, input logic [7:0] n, input logic [7:0] x,
                      input logic [39:0] d, input int nd, input logic [7:0] exp, input string m);
        logic [7:0] got;
        host.write_block(a, n, x, d, nd, got);
        chk(got === exp, m);
        tick(4);
    endtask : wr

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(slew === 9'h1ff && amp === 2'h2 && data_oe_n === 1'b1, "reset values");
        chk(data_out === 1'b0, "data drive value low");
        expect_out(9'h000, "power down at reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_gate();
        pg = 1'b1;
        tick(20);
        expect_out(9'h1ff, "all running");
        pg = 1'b0;
        tick(7);
        expect_out(9'h000, "power down");
        pg = 1'b1;
        tick(20);
        oe_pin = 9'h1f6;
        tick(12);
        expect_out(9'h1f6, "pin stops output");
        oe_pin = 9'h1ff;
        tick(12);
        expect_out(9'h1ff, "pin restarts output");
        $display("test gate done");
    endtask : t_gate

    task automatic t_write();
        wr(ADDR_LOW, IDX_OE_LO, 8'h04, 40'hfe_01aa_0000, 4, 8'h7f, "block acks");
        chk(slew === 9'h0aa && amp === 2'h1, "config stored");
        tick(12);
        expect_out(9'h0fe, "enable bits off");
        wr(ADDR_LOW, IDX_OE_LO, 8'h02, 40'hff_2233_0000, 3, 8'h1f, "extra refused");
        tick(12);
        chk(slew === 9'h0aa && amp === 2'h2, "config after restore");
        expect_out(9'h1ff, "enables back");
        $display("test write done");
    endtask : t_write

    task automatic t_reserved();
        wr(ADDR_LOW, 8'h04, 8'h04, 40'hff_ffff_0c00, 4, 8'h7f, "reserved acked");
        wr(ADDR_MID, IDX_OE_LO, 8'h01, 40'h00_0000_0000, 1, 8'h00, "other address");
        tick(12);
        chk(slew === 9'h0aa && amp === 2'h2, "nothing changed");
        expect_out(9'h1ff, "outputs unchanged");
        $display("test reserved done");
    endtask : t_reserved

    task automatic t_strap();
        reset = 1'b1;
        pg = 1'b0;
        asel = SEL_MID;
        tick(8);
        reset = 1'b0;
        tick(8);
        pg = 1'b1;
        tick(10);
        wr(ADDR_LOW, IDX_SLEW_LO, 8'h01, 40'h55_0000_0000, 1, 8'h00, "old address");
        wr(ADDR_MID, IDX_SLEW_LO, 8'h01, 40'h55_0000_0000, 1, 8'h0f, "mid address");
        chk(slew === 9'h155, "write at mid address");
        $display("test strap done");
    endtask : t_strap

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // main sequence
    initial begin
        tick(8);
        reset = 1'b0;
        tick(6);
        t_reset();
        t_gate();
        t_write();
        t_reserved();
        t_strap();
        summarize();
    end

    // watchdog: about six and a half times the expected run
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        $display("BAD t=%0t watchdog expired", $time);
        summarize();
    end

endmodule : tb_top

`default_nettype wire
